// >>> design/address_decode.sv
// 14-bit address to region decoder with local offset
`timescale 1ns/100ps
module address_decode
  import memory_map_pkg::*;
(
  input  wire logic [13:0] addr,
  output region_t          region,
  output logic      [13:0] offset
);
  always_comb begin
    region = REG_NONE;
    offset = 14'h0000;
    if (addr <= IO_LAST) begin
      region = REG_IO;
      offset = addr - IO_BASE;
    end else if (addr >= PAGE0_BASE && addr <= PAGE0_LAST) begin
      region = REG_PAGE0;
      offset = addr - PAGE0_BASE;
    end else if (addr >= RAM_BASE && addr <= RAM_LAST) begin
      region = REG_RAM;
      offset = addr - RAM_BASE;
    end else if (addr >= DEE_BASE && addr <= DEE_LAST) begin
      region = REG_DEE;
      offset = addr - DEE_BASE;
    end else if (addr >= PROG_BASE && addr <= PROG_LAST) begin
      region = REG_PROG;
      offset = addr - PROG_BASE;
    end else if (addr >= VEC_BASE) begin
      region = REG_VEC;
      offset = addr - VEC_BASE;
    end
  end
endmodule // address_decode

// >>> design/byte_memory.sv
// single-port byte memory with registered read data
`timescale 1ns/100ps
module byte_memory #(
  parameter int DEPTH = 192,
  parameter int AW    = 8
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // byte_memory

// >>> design/mcu_memory_map_decode.sv
// memory map decoder, register page and cpu data registers behind axi4-lite
// What this block does
// - register page sits at 00 to 1f
// - unimplemented bits read undefined, writes dropped
// - 192 ram bytes at 50 to 10f
// - stack from ff down to c0
// - 128 byte data nvm at 140
// - data nvm written bytewise under control register
// - program nvm 1fc0 to 3eff
// - page zero nvm 20 to 4f
// - vector nvm 3ff0 to 3fff
// - user nvm writable only in bootloader mode
// - port data 0-3, direction 4-7
// - port b data bits 7-5 only
// - port d data bits 7,5; bit4 reads one
// - port b direction bits 4-0 read one
// - port d direction bit 5 only
// - capture high 14, low 15
// - compare high 16, low 17
// - second counter copy at 1a,1b
// - analog control 1e beside result 1d
// - 8-bit accumulator
// - 8-bit index register forms address
// - 14 address lines, 16 kbyte space
`timescale 1ns/100ps
module mcu_memory_map_decode
  import memory_map_pkg::*;
#(
  parameter int PROG_BYTES = 8000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic [15:0] capture_value,
  input  wire logic [15:0] counter_value,
  input  wire logic [7:0]  analog_result,
  input  wire logic [7:0]  serial_status,
  input  wire logic [7:0]  timer_status,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe,
  output logic [7:0]       port_c_out,
  output logic [7:0]       port_c_oe,
  output logic [7:0]       nvm_control,
  output logic [7:0]       timer_control,
  output logic [15:0]      compare_value,
  output logic [7:0]       analog_control,
  output logic [5:0]       stack_index
);
  logic [7:0]  port_a_data, port_b_data, port_c_data, port_d_data;
  logic [7:0]  port_a_direction, port_b_direction, port_c_direction, port_d_direction;
  logic [7:0]  serial_control, serial_shift_data, compare_high, compare_low;
  logic [7:0]  nvm_program_control, analog_status_control;
  logic [7:0]  accumulator, index_reg;
  logic [13:0] mem_addr;
  logic        bootloader_mode;
  logic [7:0]  pc_sync1, pc_sync2;
  logic        aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        rd_pending, rd_wait;
  logic [11:0] ar_addr;
  region_t     region;
  logic [13:0] offset;
  logic        do_write, do_read;
  logic [7:0]  wbyte, io_rdata, ram_rdata, dee_rdata, pz_rdata;
  logic        ram_we, dee_we, user_we;
  function automatic logic [7:0] merge(input logic [7:0] mask, input logic [7:0] ones, input logic [7:0] v);
    return (v & mask) | ones;
  endfunction

  address_decode u_decode (
    .addr   (mem_addr),
    .region (region),
    .offset (offset)
  );

  // pin inputs pass two flops
  always_ff @(posedge aclk) begin
    pc_sync1 <= port_c_pins;
    pc_sync2 <= pc_sync1;
  end

  // write channel: address and data held independently
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wbyte         = w_data[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > AXI_EFF_ADDR || aw_addr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write side decode to the addressed window
  logic wr_mem;
  assign wr_mem  = do_write && aw_addr == AXI_MEM_DATA && w_strb[0];
  assign ram_we  = wr_mem && region == REG_RAM;
  // data nvm byte write needs program enable bit 0
  assign dee_we  = wr_mem && region == REG_DEE && nvm_program_control[0];
  // user nvm writes only in bootloader mode
  assign user_we = wr_mem && region == REG_PAGE0 && bootloader_mode;

  byte_memory #(.DEPTH(RAM_BYTES), .AW(8)) u_ram (
    .aclk  (aclk),
    .we    (ram_we),
    .addr  (offset[7:0]),
    .wdata (wbyte),
    .rdata (ram_rdata)
  );

  // data and page zero nvm storage
  byte_memory #(.DEPTH(int'(DEE_LAST - DEE_BASE) + 1), .AW(7)) u_dee (
    .aclk(aclk), .we(dee_we), .addr(offset[6:0]), .wdata(wbyte), .rdata(dee_rdata)
  );
  byte_memory #(.DEPTH(int'(PAGE0_LAST - PAGE0_BASE) + 1), .AW(6)) u_page0 (
    .aclk(aclk), .we(user_we), .addr(offset[5:0]), .wdata(wbyte), .rdata(pz_rdata)
  );
  // cpu-side register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr        <= 14'h0000;
      bootloader_mode <= 1'b0;
      accumulator     <= 8'h00;
      index_reg       <= 8'h00;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        AXI_MEM_ADDR: mem_addr        <= w_data[13:0];
        AXI_MODE:     bootloader_mode <= w_data[0];
        AXI_ACC:      accumulator     <= wbyte;
        AXI_INDEX:    index_reg       <= wbyte;
        default:      ;
      endcase
    end
  end
  assign stack_index = 6'(STACK_TOP - STACK_BOTTOM) & mem_addr[5:0];
  // register page writes
  logic io_we;
  assign io_we = wr_mem && region == REG_IO;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_data <= 8'h00;
      port_b_data <= 8'h00;
      port_c_data <= 8'h00;
      port_d_data <= 8'h00;
      port_a_direction <= 8'h00;
      port_b_direction <= 8'h00;
      port_c_direction <= 8'h00;
      port_d_direction <= 8'h00;
      serial_control <= 8'h00;
      serial_shift_data <= 8'h00;
      timer_control <= 8'h00;
      compare_high <= 8'h00;
      compare_low <= 8'h00;
      nvm_program_control <= 8'h00;
      analog_status_control <= 8'h00;
    end else if (io_we) begin
      unique case (offset[4:0])
        OFF_PORT_A_DATA: port_a_data <= wbyte;
        OFF_PORT_B_DATA: port_b_data <= wbyte & PB_DATA_MASK;
        OFF_PORT_C_DATA: port_c_data <= wbyte;
        // port d data bits 7 and 5
        OFF_PORT_D_DATA: port_d_data <= wbyte & PD_DATA_MASK;
        OFF_PORT_A_DIR:  port_a_direction <= wbyte;
        OFF_PORT_B_DIR:  port_b_direction <= wbyte & PB_DIR_MASK;
        OFF_PORT_C_DIR:  port_c_direction <= wbyte;
        OFF_PORT_D_DIR:  port_d_direction <= wbyte & PD_DIR_MASK;
        OFF_SER_CTRL:    serial_control <= wbyte & SER_CTRL_MASK;
        OFF_SER_DATA:    serial_shift_data <= wbyte;
        OFF_TMR_CTRL:    timer_control <= wbyte & TMR_CTRL_MASK;
        OFF_CMP_HI:      compare_high <= wbyte;
        OFF_CMP_LO:      compare_low <= wbyte;
        OFF_NVM_CTRL:    nvm_program_control <= wbyte & NVM_CTRL_MASK;
        OFF_ADC_CTRL:    analog_status_control <= wbyte & ADC_CTRL_MASK;
        default:         ;
      endcase
    end
  end

  assign port_a_out     = port_a_data;
  assign port_a_oe      = port_a_direction;
  assign port_c_out     = port_c_data;
  assign port_c_oe      = port_c_direction;
  assign nvm_control    = nvm_program_control;
  assign compare_value  = {compare_high, compare_low};
  assign analog_control = analog_status_control;
  // register page read mux
  always_comb begin
    unique case (offset[4:0])
      OFF_PORT_A_DATA: io_rdata = port_a_data;
      OFF_PORT_B_DATA: io_rdata = merge(PB_DATA_MASK, 8'h00, port_b_data);
      OFF_PORT_C_DATA: io_rdata = (port_c_data & port_c_direction) | (pc_sync2 & ~port_c_direction);
      OFF_PORT_D_DATA: io_rdata = merge(PD_DATA_MASK, PD_DATA_ONES, port_d_data);
      OFF_PORT_A_DIR:  io_rdata = port_a_direction;
      OFF_PORT_B_DIR:  io_rdata = merge(PB_DIR_MASK, PB_DIR_ONES, port_b_direction);
      OFF_PORT_C_DIR:  io_rdata = port_c_direction;
      OFF_PORT_D_DIR:  io_rdata = merge(PD_DIR_MASK, 8'h00, port_d_direction);
      OFF_SER_CTRL:    io_rdata = serial_control;
      OFF_SER_STAT:    io_rdata = serial_status;
      OFF_SER_DATA:    io_rdata = serial_shift_data;
      OFF_TMR_CTRL:    io_rdata = timer_control;
      OFF_TMR_STAT:    io_rdata = timer_status;
      OFF_CAP_HI:      io_rdata = capture_value[15:8];
      OFF_CAP_LO:      io_rdata = capture_value[7:0];
      OFF_CMP_HI:      io_rdata = compare_high;
      OFF_CMP_LO:      io_rdata = compare_low;
      OFF_CNT_HI:      io_rdata = counter_value[15:8];
      OFF_CNT_LO:      io_rdata = counter_value[7:0];
      OFF_CNT2_HI:     io_rdata = counter_value[15:8];
      OFF_CNT2_LO:     io_rdata = counter_value[7:0];
      OFF_NVM_CTRL:    io_rdata = nvm_program_control;
      OFF_ADC_RESULT:  io_rdata = analog_result;
      OFF_ADC_CTRL:    io_rdata = analog_status_control;
      default:         io_rdata = UNDEF_READ;
    endcase
  end

  // read channel: one cycle wait so memory data settles
  assign s_axi_arready = !rd_pending && !s_axi_rvalid;
  assign do_read       = rd_pending && !rd_wait;

  region_t rd_region;
  always_ff @(posedge aclk) begin
    rd_region <= region;
  end
  logic [7:0] mem_byte;
  always_comb begin
    unique case (rd_region)
      REG_IO:    mem_byte = io_rdata;
      REG_RAM:   mem_byte = ram_rdata;
      REG_DEE:   mem_byte = dee_rdata;
      REG_PAGE0: mem_byte = pz_rdata;
      default:   mem_byte = UNDEF_READ;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pending   <= 1'b0;
      rd_wait      <= 1'b0;
      ar_addr      <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pending <= 1'b1;
        rd_wait    <= 1'b1;
        ar_addr    <= s_axi_araddr;
      end else if (rd_wait) begin
        rd_wait <= 1'b0;
      end
      if (do_read) begin
        rd_pending   <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (ar_addr)
          AXI_MEM_ADDR: s_axi_rdata <= {18'h0, mem_addr};
          AXI_MEM_DATA: s_axi_rdata <= {24'h0, mem_byte};
          AXI_MODE:     s_axi_rdata <= {31'h0, bootloader_mode};
          AXI_ACC:      s_axi_rdata <= {24'h0, accumulator};
          AXI_INDEX:    s_axi_rdata <= {24'h0, index_reg};
          AXI_REGION:   s_axi_rdata <= {29'h0, region};
          AXI_EFF_ADDR: s_axi_rdata <= {18'h0, mem_addr + {6'h00, index_reg}};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // port b data low bits never set
  AST_PB_LOW: assert property (@(posedge aclk) disable iff (!aresetn) port_b_data[4:0] == 5'h00)
    else $error("port b data low bits set");
  // port d direction only bit 5
  AST_PD_DIR: assert property (@(posedge aclk) disable iff (!aresetn) (port_d_direction & ~PD_DIR_MASK) == 8'h00)
    else $error("port d direction stray bit");
  // no user nvm write in user mode
  AST_BOOT: assert property (@(posedge aclk) disable iff (!aresetn) user_we |-> bootloader_mode)
    else $error("user nvm written outside bootloader");
  AST_DEE: assert property (@(posedge aclk) disable iff (!aresetn) dee_we |-> nvm_program_control[0])
    else $error("data nvm written without enable");
  AST_IO: assert property (@(posedge aclk) disable iff (!aresetn) region == REG_IO |-> mem_addr <= IO_LAST)
    else $error("register page decoded out of range");
  AST_RAM: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_addr >= RAM_BASE && mem_addr <= RAM_LAST) |-> region == REG_RAM)
    else $error("ram address not decoded");
  AST_PROG: assert property (@(posedge aclk) disable iff (!aresetn) region == REG_PROG |-> offset < 14'(PROG_BYTES))
    else $error("program window too large");
  // read answer three edges after address
  AST_RD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |-> ##3 s_axi_rvalid)
    else $error("read answer late");
  AST_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && w_strb[0] && aw_addr == AXI_ACC) |=> accumulator == $past(wbyte))
    else $error("accumulator not written");
endmodule // mcu_memory_map_decode

// >>> include/memory_map_pkg.sv
// constants for the memory map decoder and register page
package memory_map_pkg;
  localparam int          ADDR_W        = 14;
  localparam int          DATA_W        = 8;
  localparam logic [13:0] IO_BASE       = 14'h0000;
  localparam logic [13:0] IO_LAST       = 14'h001f;
  localparam logic [13:0] PAGE0_BASE    = 14'h0020;
  localparam logic [13:0] PAGE0_LAST    = 14'h004f;
  localparam logic [13:0] RAM_BASE      = 14'h0050;
  localparam logic [13:0] RAM_LAST      = 14'h010f;
  localparam int          RAM_BYTES     = 192;
  localparam logic [13:0] STACK_TOP     = 14'h00ff;
  localparam logic [13:0] STACK_BOTTOM  = 14'h00c0;
  localparam logic [13:0] DEE_BASE      = 14'h0140;
  localparam logic [13:0] DEE_LAST      = 14'h01bf;
  localparam logic [13:0] PROG_BASE     = 14'h1fc0;
  localparam logic [13:0] PROG_LAST     = 14'h3eff;
  localparam logic [13:0] VEC_BASE      = 14'h3ff0;
  localparam logic [13:0] VEC_LAST      = 14'h3fff;
  // register page offsets
  localparam logic [4:0] OFF_PORT_A_DATA = 5'h00;
  localparam logic [4:0] OFF_PORT_B_DATA = 5'h01;
  localparam logic [4:0] OFF_PORT_C_DATA = 5'h02;
  localparam logic [4:0] OFF_PORT_D_DATA = 5'h03;
  localparam logic [4:0] OFF_PORT_A_DIR  = 5'h04;
  localparam logic [4:0] OFF_PORT_B_DIR  = 5'h05;
  localparam logic [4:0] OFF_PORT_C_DIR  = 5'h06;
  localparam logic [4:0] OFF_PORT_D_DIR  = 5'h07;
  localparam logic [4:0] OFF_SER_CTRL    = 5'h0a;
  localparam logic [4:0] OFF_SER_STAT    = 5'h0b;
  localparam logic [4:0] OFF_SER_DATA    = 5'h0c;
  localparam logic [4:0] OFF_TMR_CTRL    = 5'h12;
  localparam logic [4:0] OFF_TMR_STAT    = 5'h13;
  localparam logic [4:0] OFF_CAP_HI      = 5'h14;
  localparam logic [4:0] OFF_CAP_LO      = 5'h15;
  localparam logic [4:0] OFF_CMP_HI      = 5'h16;
  localparam logic [4:0] OFF_CMP_LO      = 5'h17;
  localparam logic [4:0] OFF_CNT_HI      = 5'h18;
  localparam logic [4:0] OFF_CNT_LO      = 5'h19;
  localparam logic [4:0] OFF_CNT2_HI     = 5'h1a;
  localparam logic [4:0] OFF_CNT2_LO     = 5'h1b;
  localparam logic [4:0] OFF_NVM_CTRL    = 5'h1c;
  localparam logic [4:0] OFF_ADC_RESULT  = 5'h1d;
  localparam logic [4:0] OFF_ADC_CTRL    = 5'h1e;
  // implemented-bit masks and fixed read bits
  localparam logic [7:0] PB_DATA_MASK    = 8'he0;
  localparam logic [7:0] PD_DATA_MASK    = 8'ha0;
  localparam logic [7:0] PD_DATA_ONES    = 8'h10;
  localparam logic [7:0] PB_DIR_MASK     = 8'he0;
  localparam logic [7:0] PB_DIR_ONES     = 8'h1f;
  localparam logic [7:0] PD_DIR_MASK     = 8'h20;
  localparam logic [7:0] SER_CTRL_MASK   = 8'h50;
  localparam logic [7:0] TMR_CTRL_MASK   = 8'he3;
  localparam logic [7:0] NVM_CTRL_MASK   = 8'h5f;
  localparam logic [7:0] ADC_CTRL_MASK   = 8'h27;
  localparam logic [7:0] UNDEF_READ      = 8'h00;
  // cpu-side extras, byte addresses on the bus
  localparam logic [11:0] AXI_MEM_ADDR   = 12'h000;
  localparam logic [11:0] AXI_MEM_DATA   = 12'h004;
  localparam logic [11:0] AXI_MODE       = 12'h008;
  localparam logic [11:0] AXI_ACC        = 12'h00c;
  localparam logic [11:0] AXI_INDEX      = 12'h010;
  localparam logic [11:0] AXI_REGION     = 12'h014;
  localparam logic [11:0] AXI_EFF_ADDR   = 12'h018;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  typedef enum logic [2:0] {REG_IO, REG_PAGE0, REG_RAM, REG_DEE, REG_PROG, REG_VEC, REG_NONE} region_t;
endpackage

// >>> verification/mcu_memory_map_decode_bench.sv
// bus-driven bench for the memory map decoder
`timescale 1ns/100ps
module mcu_memory_map_decode_bench
  import memory_map_pkg::*;
;
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  port_c_pins, analog_result, serial_status, timer_status;
  logic [15:0] capture_value, counter_value, compare_value;
  logic [7:0]  port_a_out, port_a_oe, port_c_out, port_c_oe;
  logic [7:0]  nvm_control, timer_control, analog_control;
  logic [5:0]  stack_index;
  int          errors, n_compared, k;
  // offset, written byte, expected read
  localparam logic [23:0] PAGE_TBL [19] = '{
    24'h00ffff, 24'h01ffe0, 24'h032030, 24'h04a5a5, 24'h05405f,
    24'h07ff20, 24'h060f0f, 24'h02ff3f, 24'h161212, 24'h173434,
    24'h08ff00, 24'h1400c3, 24'h1500a5, 24'h1a005a, 24'h1b0096,
    24'h1d007e, 24'h1eff27, 24'h12ffe3, 24'h130040
  };
  // address, region code
  localparam logic [23:0] AREA_TBL [13] = '{
    24'h001f00, 24'h002001, 24'h004f01, 24'h005002, 24'h010f02,
    24'h011006, 24'h014003, 24'h01bf03, 24'h1fc004, 24'h3eff04,
    24'h3f0006, 24'h3ff005, 24'h3fff05
  };

  mcu_memory_map_decode #(.PROG_BYTES(8000)) uut (.*);
  periph_model far (.*);

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int   i;
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    if (i == 40) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    int   i;
    logic ta, tb;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) break;
    end
    if (i == 40) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic put(input logic [13:0] a, input logic [7:0] d);
    wr(AXI_MEM_ADDR, {18'h0, a});
    wr(AXI_MEM_DATA, {24'h0, d});
  endtask

  task automatic get(input string n, input logic [13:0] a, input logic [7:0] e);
    wr(AXI_MEM_ADDR, {18'h0, a});
    rd(AXI_MEM_DATA);
    check(n, rdat, {24'h0, e});
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    errors = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 19; k++) begin
      put({9'h0, PAGE_TBL[k][20:16]}, PAGE_TBL[k][15:8]);
      get("page reg", {9'h0, PAGE_TBL[k][20:16]}, PAGE_TBL[k][7:0]);
    end
    check("compare out", {16'h0, compare_value}, 32'h1234);
    check("port c oe", {24'h0, port_c_oe}, 32'h0f);
    check("port a out", {24'h0, port_a_out}, 32'hff);
    check("port a oe", {24'h0, port_a_oe}, 32'ha5);
    check("port c out", {24'h0, port_c_out}, 32'hff);
    check("timer control", {24'h0, timer_control}, 32'he3);
    check("analog control", {24'h0, analog_control}, 32'h27);
    $display("test register page done");
    for (k = 0; k < 13; k++) begin
      wr(AXI_MEM_ADDR, {18'h0, AREA_TBL[k][21:8]});
      rd(AXI_REGION);
      check("region", rdat, {24'h0, AREA_TBL[k][7:0]});
    end
    $display("test region decode done");
    put(14'h0050, 8'h11);
    put(14'h010f, 8'h22);
    get("ram low", 14'h0050, 8'h11);
    get("ram high", 14'h010f, 8'h22);
    get("unmapped", 14'h0110, 8'h00);
    wr(AXI_MEM_ADDR, 32'h00c0);
    check("stack bottom", {26'h0, stack_index}, 32'h0);
    wr(AXI_MEM_ADDR, 32'h00ff);
    check("stack top", {26'h0, stack_index}, 32'h3f);
    $display("test ram done");
    put(14'h001c, 8'h01);
    check("nvm control", {24'h0, nvm_control}, 32'h01);
    put(14'h01bf, 8'h55);
    put(14'h001c, 8'h00);
    put(14'h01bf, 8'h99);
    get("data nvm", 14'h01bf, 8'h55);
    wr(AXI_MODE, 32'h1);
    put(14'h0020, 8'h5a);
    wr(AXI_MODE, 32'h0);
    put(14'h0020, 8'ha5);
    get("page zero nvm", 14'h0020, 8'h5a);
    $display("test nvm done");
    wr(AXI_ACC, 32'h1ab);
    rd(AXI_ACC);
    check("accumulator", rdat, 32'hab);
    wr(AXI_INDEX, 32'h20);
    wr(AXI_MEM_ADDR, 32'h0100);
    rd(AXI_EFF_ADDR);
    check("effective address", rdat, 32'h120);
    wr(12'h01c, 32'h1);
    check("bad write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(12'h01c);
    check("bad read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("test cpu registers done");
    give_verdict();
  end
endmodule // mcu_memory_map_decode_bench

// >>> verification/periph_model.sv
// peripheral levels seen through the register page
`timescale 1ns/100ps
module periph_model (
  output logic [7:0]  port_c_pins,
  output logic [15:0] capture_value,
  output logic [15:0] counter_value,
  output logic [7:0]  analog_result,
  output logic [7:0]  serial_status,
  output logic [7:0]  timer_status
);
  assign port_c_pins   = 8'h3c;
  assign capture_value = 16'hc3a5;
  assign counter_value = 16'h5a96;
  assign analog_result = 8'h7e;
  assign serial_status = 8'h80;
  assign timer_status  = 8'h40;
endmodule // periph_model
